//--- rtl/iplr_regs.sv
/*
 * iplr_regs: interrupt priority level registers behind an AXI4-Lite slave.
 * Holds the lock-change field, the serial/port-A register, the
 * converter/timer register and the pulse/converter register, and presents
 * every enabled request with its decoded level to the core arbitration.
 * Assumes a single clock, AXI4-Lite master on the same clock, and raw
 * request levels synchronous to CLK.
 */
// Added by the designer: the AXI4-Lite register port.
// Overview of operation
// - lock-change level is bits 1-0 of the register before; 00 off.
// - uart receive-full level sits in bits 15-14 of serial register.
// - uart receive-error level sits in bits 13-12 of serial register.
// - uart transmit-idle level sits in bits 9-8 of serial register.
// - uart transmit-empty level sits in bits 7-6 of serial register.
// - sync serial transmit-empty level in bits 5-4 of serial register.
// - sync serial receive-full level in bits 3-2 of serial register.
// - port A level sits in bits 1-0 of serial register.
// - converter A done level sits in bits 15-14 of converter register.
// - timer channel 3 level sits in bits 13-12 of converter register.
// - timer channel 2 level sits in bits 11-10 of converter register.
// - timer channel 1 level sits in bits 9-8 of converter register.
// - timer channel 0 level sits in bits 7-6 of converter register.
// - two-wire address match level in bits 5-4 of converter register.
// - pulse fault level sits in bits 7-6 of pulse register.
// - pulse reload level sits in bits 5-4 of pulse register.
// - converter zero/limit level sits in bits 3-2 of pulse register.
// - unimplemented bits read zero and ignore writes.
// - reset clears every field, disabling every request.
`timescale 1ns/1ns
module iplr_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [iplr_pkg::NUM_SRC-1:0] IRQ_IN,
    output iplr_pkg::iplr_req_t [iplr_pkg::NUM_SRC-1:0] IRQ_OUT
);

    // address must reach index 4 plus the byte offset bits
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
        $error("iplr_regs: ADDR_W must lie in 5..32");
    end

    // reset release
    logic rst_meta_r;
    logic rst_n_r;

    // register contents
    logic [15:0] lock_prio_r;
    logic [15:0] serial_gpio_priority_r;
    logic [15:0] adc_timer_priority_r;
    logic [15:0] pwm_adc_priority_r;

    // write channel state
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    iplr_pkg::iplr_wbeat_t w_beat_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    // read channel state
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // arbitration side
    iplr_pkg::iplr_req_t [iplr_pkg::NUM_SRC-1:0] irq_out_r;
    iplr_pkg::iplr_req_t [iplr_pkg::NUM_SRC-1:0] irq_nxt;
    logic [1:0] fld [iplr_pkg::NUM_SRC];

    // handshakes
    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic ar_fire;
    logic r_fire;
    logic do_write;

    // write decode results
    logic wr_lock;
    logic wr_serial;
    logic wr_adc_tmr;
    logic wr_pwm;
    logic wr_hit;
    logic [15:0] wr_data;
    logic [1:0] wr_strb;

    // register index from a byte address
    function automatic int reg_index(input logic [ADDR_W-1:0] addr);
        return int'(addr >> iplr_pkg::BYTE_SHIFT);
    endfunction

    // merge a 16-bit write into a register under lane strobes and mask
    function automatic logic [15:0] wr_merge(
        input logic [15:0] old,
        input logic [15:0] data,
        input logic [1:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lane) | (data & lane);
    endfunction

    // two-flop reset release, asynchronous assert
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // channel handshakes
    assign aw_fire = S_AXI_AWVALID & awready_r;
    assign w_fire = S_AXI_WVALID & wready_r;
    assign b_fire = bvalid_r & S_AXI_BREADY;
    assign ar_fire = S_AXI_ARVALID & arready_r;
    assign r_fire = rvalid_r & S_AXI_RREADY;
    assign do_write = aw_held_r & w_held_r & ~bvalid_r;

    // write address capture, released once the response is taken
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else begin
            if (aw_fire) begin
                awready_r <= 1'b0;
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end else if (b_fire) begin
                awready_r <= 1'b1;
            end
        end
    end

    // write data capture, in either order with the address
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
            w_beat_r <= '0;
        end else begin
            if (w_fire) begin
                wready_r <= 1'b0;
                w_held_r <= 1'b1;
                w_beat_r.data <= S_AXI_WDATA;
                w_beat_r.strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end else if (b_fire) begin
                wready_r <= 1'b1;
            end
        end
    end

    // write address decode; unmapped index answers with an error
    always_comb begin
        wr_lock = 1'b0;
        wr_serial = 1'b0;
        wr_adc_tmr = 1'b0;
        wr_pwm = 1'b0;
        if (reg_index(aw_addr_r) == iplr_pkg::IDX_LOCK) begin
            wr_lock = 1'b1;
        end else if (reg_index(aw_addr_r) == iplr_pkg::IDX_SERIAL) begin
            wr_serial = 1'b1;
        end else if (reg_index(aw_addr_r) == iplr_pkg::IDX_ADC_TMR) begin
            wr_adc_tmr = 1'b1;
        end else if (reg_index(aw_addr_r) == iplr_pkg::IDX_PWM) begin
            wr_pwm = 1'b1;
        end
    end

    assign wr_hit = wr_lock | wr_serial | wr_adc_tmr | wr_pwm;
    assign wr_data = w_beat_r.data[15:0];
    assign wr_strb = w_beat_r.strb[1:0];

    // write response, one cycle after both beats are held
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bvalid_r <= 1'b0;
            bresp_r <= iplr_pkg::RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR;
            end else if (b_fire) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lock_prio_r <= iplr_pkg::REG_RESET;
            serial_gpio_priority_r <= iplr_pkg::REG_RESET;
            adc_timer_priority_r <= iplr_pkg::REG_RESET;
            pwm_adc_priority_r <= iplr_pkg::REG_RESET;
        end else if (do_write) begin
            if (wr_lock) begin
                lock_prio_r <= wr_merge(lock_prio_r, wr_data, wr_strb, iplr_pkg::MASK_LOCK);
            end
            if (wr_serial) begin
                serial_gpio_priority_r <= wr_merge(serial_gpio_priority_r, wr_data, wr_strb,
                                                   iplr_pkg::MASK_SERIAL);
            end
            if (wr_adc_tmr) begin
                adc_timer_priority_r <= wr_merge(adc_timer_priority_r, wr_data, wr_strb,
                                                 iplr_pkg::MASK_ADC_TMR);
            end
            if (wr_pwm) begin
                pwm_adc_priority_r <= wr_merge(pwm_adc_priority_r, wr_data, wr_strb,
                                               iplr_pkg::MASK_PWM);
            end
        end
    end

    // read: data and response one cycle after the address is taken
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= iplr_pkg::RESP_OKAY;
        end else begin
            if (ar_fire) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rresp_r <= iplr_pkg::RESP_OKAY;
                if (reg_index(S_AXI_ARADDR) == iplr_pkg::IDX_LOCK) begin
                    rdata_r <= {16'h0000, lock_prio_r & iplr_pkg::MASK_LOCK};
                end else if (reg_index(S_AXI_ARADDR) == iplr_pkg::IDX_SERIAL) begin
                    rdata_r <= {16'h0000, serial_gpio_priority_r & iplr_pkg::MASK_SERIAL};
                end else if (reg_index(S_AXI_ARADDR) == iplr_pkg::IDX_ADC_TMR) begin
                    rdata_r <= {16'h0000, adc_timer_priority_r & iplr_pkg::MASK_ADC_TMR};
                end else if (reg_index(S_AXI_ARADDR) == iplr_pkg::IDX_PWM) begin
                    rdata_r <= {16'h0000, pwm_adc_priority_r & iplr_pkg::MASK_PWM};
                end else begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= iplr_pkg::RESP_SLVERR; // unmapped
                end
            end else if (r_fire) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // field extraction per source
    always_comb begin
        fld[iplr_pkg::SRC_LOCK] = lock_prio_r[iplr_pkg::LSB_LOCK +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_UART_RX_FULL] =
            serial_gpio_priority_r[iplr_pkg::LSB_UART_RX_FULL +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_UART_RX_ERROR] =
            serial_gpio_priority_r[iplr_pkg::LSB_UART_RX_ERROR +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_UART_TX_IDLE] =
            serial_gpio_priority_r[iplr_pkg::LSB_UART_TX_IDLE +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_UART_TX_EMPTY] =
            serial_gpio_priority_r[iplr_pkg::LSB_UART_TX_EMPTY +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_SYNC_TX_EMPTY] =
            serial_gpio_priority_r[iplr_pkg::LSB_SYNC_TX_EMPTY +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_SYNC_RX_FULL] =
            serial_gpio_priority_r[iplr_pkg::LSB_SYNC_RX_FULL +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_PORT_A] = serial_gpio_priority_r[iplr_pkg::LSB_PORT_A +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_CONV_A_DONE] =
            adc_timer_priority_r[iplr_pkg::LSB_CONV_A_DONE +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_TIMER_CH3] = adc_timer_priority_r[iplr_pkg::LSB_TIMER_CH3 +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_TIMER_CH2] = adc_timer_priority_r[iplr_pkg::LSB_TIMER_CH2 +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_TIMER_CH1] = adc_timer_priority_r[iplr_pkg::LSB_TIMER_CH1 +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_TIMER_CH0] = adc_timer_priority_r[iplr_pkg::LSB_TIMER_CH0 +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_TWO_WIRE] = adc_timer_priority_r[iplr_pkg::LSB_TWO_WIRE +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_PULSE_FAULT] =
            pwm_adc_priority_r[iplr_pkg::LSB_PULSE_FAULT +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_PULSE_RELOAD] =
            pwm_adc_priority_r[iplr_pkg::LSB_PULSE_RELOAD +: iplr_pkg::FLD_W];
        fld[iplr_pkg::SRC_CONV_ZERO_LIMIT] =
            pwm_adc_priority_r[iplr_pkg::LSB_CONV_ZERO_LIMIT +: iplr_pkg::FLD_W];
        // converter B done shares the pulse register low bits
        fld[iplr_pkg::SRC_CONV_B_DONE] =
            pwm_adc_priority_r[iplr_pkg::LSB_CONV_B_DONE +: iplr_pkg::FLD_W];
    end

    for (genvar i = 0; i < iplr_pkg::NUM_SRC; i++) begin : g_dec
        iplr_level_decode u_dec (
            .field(fld[i]),
            .req(IRQ_IN[i]),
            .dec(irq_nxt[i])
        );
    end

    // registered view for arbitration
    always_ff @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_out_r <= '0;
        end else begin
            irq_out_r <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign IRQ_OUT = irq_out_r;

endmodule // iplr_regs

//--- rtl/iplr_pkg.sv
/*
 * iplr_pkg: shared constants and types for the interrupt priority level
 * registers: register indices, implemented-bit masks, field positions,
 * source numbering, bus response codes and the per-source level carrier.
 * Assumes a 32-bit AXI4-Lite register bus and 16-bit registers.
 */
package iplr_pkg;

    // register indices as printed; byte address is four times the index
    localparam int IDX_LOCK = 1;
    localparam int IDX_SERIAL = 2;
    localparam int IDX_ADC_TMR = 3;
    localparam int IDX_PWM = 4;
    localparam int BYTE_SHIFT = 2;

    // register geometry
    localparam int REG_W = 16;
    localparam int FLD_W = 2;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // implemented bits; all others read zero and ignore writes
    localparam logic [15:0] MASK_LOCK = 16'h0003;
    localparam logic [15:0] MASK_SERIAL = 16'hf3ff;
    localparam logic [15:0] MASK_ADC_TMR = 16'hfff0;
    localparam logic [15:0] MASK_PWM = 16'h00ff;

    // field low-bit positions
    localparam int LSB_LOCK = 0;
    localparam int LSB_UART_RX_FULL = 14;
    localparam int LSB_UART_RX_ERROR = 12;
    localparam int LSB_UART_TX_IDLE = 8;
    localparam int LSB_UART_TX_EMPTY = 6;
    localparam int LSB_SYNC_TX_EMPTY = 4;
    localparam int LSB_SYNC_RX_FULL = 2;
    localparam int LSB_PORT_A = 0;
    localparam int LSB_CONV_A_DONE = 14;
    localparam int LSB_TIMER_CH3 = 12;
    localparam int LSB_TIMER_CH2 = 10;
    localparam int LSB_TIMER_CH1 = 8;
    localparam int LSB_TIMER_CH0 = 6;
    localparam int LSB_TWO_WIRE = 4;
    localparam int LSB_PULSE_FAULT = 6;
    localparam int LSB_PULSE_RELOAD = 4;
    localparam int LSB_CONV_ZERO_LIMIT = 2;
    localparam int LSB_CONV_B_DONE = 0;

    // source numbering on the request and level vectors
    localparam int NUM_SRC = 18;
    localparam int SRC_LOCK = 0;
    localparam int SRC_UART_RX_FULL = 1;
    localparam int SRC_UART_RX_ERROR = 2;
    localparam int SRC_UART_TX_IDLE = 3;
    localparam int SRC_UART_TX_EMPTY = 4;
    localparam int SRC_SYNC_TX_EMPTY = 5;
    localparam int SRC_SYNC_RX_FULL = 6;
    localparam int SRC_PORT_A = 7;
    localparam int SRC_CONV_A_DONE = 8;
    localparam int SRC_TIMER_CH3 = 9;
    localparam int SRC_TIMER_CH2 = 10;
    localparam int SRC_TIMER_CH1 = 11;
    localparam int SRC_TIMER_CH0 = 12;
    localparam int SRC_TWO_WIRE = 13;
    localparam int SRC_PULSE_FAULT = 14;
    localparam int SRC_PULSE_RELOAD = 15;
    localparam int SRC_CONV_ZERO_LIMIT = 16;
    localparam int SRC_CONV_B_DONE = 17;

    // field encoding
    localparam logic [1:0] FLD_DISABLED = 2'h0;
    localparam logic [1:0] FLD_STEP = 2'h1;

    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one request as presented to arbitration
    typedef struct packed {
        logic active;
        logic [1:0] level;
    } iplr_req_t;

    // held write data beat
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
    } iplr_wbeat_t;

endpackage

//--- rtl/iplr_level_decode.sv
/*
 * iplr_level_decode: turns one 2-bit priority field and its raw request
 * into the enable and level seen by arbitration. Purely combinational;
 * the caller registers the result.
 */
`timescale 1ns/1ns
module iplr_level_decode (
    input wire logic [1:0] field,
    input wire logic req,
    output iplr_pkg::iplr_req_t dec
);

    logic enabled;

    // zero field blocks the request, others map to level field-1
    assign enabled = (field != iplr_pkg::FLD_DISABLED);
    assign dec.active = enabled & req;
    assign dec.level = enabled ? (field - iplr_pkg::FLD_STEP) : iplr_pkg::FLD_DISABLED;

endmodule // iplr_level_decode

//--- test/iplr_regs_asserts.sv
/*
 * iplr_regs_asserts: concurrent checks on the ports of the priority level
 * register block. Assumes it is bound onto iplr_regs, one clock, NRST low.
 */
`timescale 1ns/1ns
module iplr_regs_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [iplr_pkg::NUM_SRC-1:0] IRQ_IN,
    input wire iplr_pkg::iplr_req_t [iplr_pkg::NUM_SRC-1:0] IRQ_OUT
);
    logic [ADDR_W-3:0] rd_idx_r;
    logic [iplr_pkg::NUM_SRC-1:0] act_vec;
    logic [iplr_pkg::NUM_SRC-1:0] lvl3_vec;

    // implemented bits of each index, zero where unmapped
    function automatic logic [15:0] imp_mask(input logic [ADDR_W-3:0] idx);
        case (idx)
            1: return iplr_pkg::MASK_LOCK;
            2: return iplr_pkg::MASK_SERIAL;
            3: return iplr_pkg::MASK_ADC_TMR;
            4: return iplr_pkg::MASK_PWM;
            default: return 16'h0000;
        endcase
    endfunction

    // remember which index the pending read targets
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_idx_r <= '0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd_idx_r <= S_AXI_ARADDR[ADDR_W-1:2];
        end
    end

    // flatten the request structs
    always_comb begin
        for (int i = 0; i < iplr_pkg::NUM_SRC; i++) begin
            act_vec[i] = IRQ_OUT[i].active;
            lvl3_vec[i] = (IRQ_OUT[i].level == 2'h3);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_rd_reserved_zero: assert property (
        S_AXI_RVALID |-> (S_AXI_RDATA & ~{16'h0000, imp_mask(rd_idx_r)}) == 32'h0)
        else $error("read data has bits outside implemented fields");
    a_rd_unmapped_err: assert property (
        S_AXI_RVALID && imp_mask(rd_idx_r) == 16'h0000 |-> S_AXI_RRESP == iplr_pkg::RESP_SLVERR)
        else $error("unmapped read not answered with slave error");
    a_rd_mapped_okay: assert property (
        S_AXI_RVALID && imp_mask(rd_idx_r) != 16'h0000 |-> S_AXI_RRESP == iplr_pkg::RESP_OKAY)
        else $error("mapped read not answered okay");
    a_irq_needs_req: assert property (
        (act_vec & ~$past(IRQ_IN)) == '0)
        else $error("request active without a raw request one cycle before");
    a_level_max_two: assert property (
        lvl3_vec == '0)
        else $error("decoded level above two");
    a_reset_clear: assert property (
        $rose(NRST) |-> act_vec == '0 [*2])
        else $error("request active right after reset");
    a_r_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("read answer dropped or changed before ready");
    a_b_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped or changed before ready");
    a_wr_answer: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
    a_rd_answer: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
        else $error("read response late");
endmodule // iplr_regs_asserts

//--- test/iplr_arb_model.sv
/*
 * iplr_arb_model: behavioural core arbitration fed by the decoded requests.
 * Assumes the requests are settled registered values.
 */
`timescale 1ns/1ns
module iplr_arb_model (
    input wire iplr_pkg::iplr_req_t [iplr_pkg::NUM_SRC-1:0] reqs,
    output logic pick_valid,
    output logic [1:0] pick_level,
    output logic [4:0] pick_src
);
    // highest level wins, lowest source number breaks ties
    always_comb begin
        pick_valid = 1'b0;
        pick_level = 2'h0;
        pick_src = 5'h00;
        for (int i = 0; i < iplr_pkg::NUM_SRC; i++) begin
            if (reqs[i].active && (!pick_valid || reqs[i].level > pick_level)) begin
                pick_valid = 1'b1;
                pick_level = reqs[i].level;
                pick_src = 5'(i);
            end
        end
    end
endmodule // iplr_arb_model

//--- test/irq_priority_level_regs_tb_top.sv
/*
 * irq_priority_level_regs_tb_top: self-checking bench for iplr_regs with a
 * register model and a request decode model. Assumes 4 ns clock, AXI4-Lite.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module irq_priority_level_regs_tb_top;
    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [17:0] irq_in;
    iplr_pkg::iplr_req_t [17:0] irq_out;
    logic pick_valid;
    logic [1:0] pick_level;
    logic [15:0] regs [1:4];
    logic [31:0] d;
    int fail_count, samples_checked, seed;
    int src_idx [18] = '{1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 4, 4, 4, 4};
    int src_lsb [18] = '{0, 14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 6, 4, 2, 0};
    logic [15:0] masks [1:4] = '{16'h0003, 16'hf3ff, 16'hfff0, 16'h00ff};

    iplr_regs #(.ADDR_W(8)) i_iplr_regs (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IRQ_IN(irq_in), .IRQ_OUT(irq_out));
    iplr_arb_model i_iplr_arb_model (.reqs(irq_out), .pick_valid(pick_valid), .pick_level(pick_level),
        .pick_src());

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // bus write, address and data offered together
    task automatic axi_write(input int idx, input logic [31:0] dat, input logic [3:0] stb);
        bit aw_p, w_p;
        aw_p = 1;
        w_p = 1;
        @(posedge clk);
        awaddr <= 8'(idx * 4);
        awvalid <= 1'b1;
        wdata <= dat;
        wstrb <= stb;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_p && awready) begin aw_p = 0; awvalid <= 1'b0; end
            if (w_p && wready) begin w_p = 0; wvalid <= 1'b0; end
        end while (aw_p || w_p);
        while (!bvalid) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        rsp = bresp;
        bready <= 1'b0;
        `CHK(rsp, (idx >= 1 && idx <= 4) ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR)
        if (idx >= 1 && idx <= 4) begin
            if (stb[0]) regs[idx][7:0] = dat[7:0] & masks[idx][7:0];
            if (stb[1]) regs[idx][15:8] = dat[15:8] & masks[idx][15:8];
        end
    endtask

    // bus read compared with the register model
    task automatic axi_read(input int idx);
        @(posedge clk);
        araddr <= 8'(idx * 4);
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (idx >= 1 && idx <= 4) begin
            `CHK(d, {16'h0000, regs[idx]})
            `CHK(rsp, iplr_pkg::RESP_OKAY)
        end else begin
            `CHK(d, 32'h0)
            `CHK(rsp, iplr_pkg::RESP_SLVERR)
        end
    endtask

    // random raw requests, decoded outputs against the field model
    task automatic check_irq();
        logic [17:0] req;
        logic [2:0] e;
        int f, best;
        req = 18'($urandom);
        irq_in <= req;
        repeat (2) @(posedge clk);
        best = -1;
        for (int i = 0; i < 18; i++) begin
            f = (regs[src_idx[i]] >> src_lsb[i]) & 3;
            e = {req[i] && f != 0, (f != 0) ? 2'(f - 1) : 2'h0};
            if (i < 8) `CHK(irq_out[i], e)
            else `CHK(irq_out[i], e)
            if (e[2] && int'(e[1:0]) > best) best = int'(e[1:0]);
        end
        `CHK(pick_valid, 1'(best >= 0))
        if (best >= 0) `CHK(pick_level, 2'(best))
    endtask

    // reset pulse, then all registers and requests must be clear
    task automatic reset_and_check();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 1; i <= 4; i++) regs[i] = 16'h0000;
        for (int i = 1; i <= 4; i++) axi_read(i);
        check_irq();
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #80000;
        fail_count++;
        print_verdict();
    end

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, irq_in} = '0;
        seed = $urandom(73);
        reset_and_check();
        $display("test reset values done");
        // unmapped places refuse writes and read zero
        foreach (masks[i]) axi_write(i + 4, 32'hffffffff, 4'hf);
        axi_write(0, 32'hffffffff, 4'hf);
        for (int i = 0; i <= 6; i++) axi_read(i);
        $display("test unmapped access done");
        // every field code first, then random data and strobes
        for (int k = 0; k < 24; k++) begin
            for (int i = 1; i <= 4; i++) begin
                if (k < 4) axi_write(i, {16'hffff, {8{2'(k)}}}, 4'hf);
                else axi_write(i, $urandom, 4'($urandom));
            end
            for (int i = 1; i <= 4; i++) axi_read(i);
            check_irq();
        end
        $display("test field decode done");
        reset_and_check();
        $display("test second reset done");
        print_verdict();
    end
endmodule // irq_priority_level_regs_tb_top

bind iplr_regs iplr_regs_asserts #(.ADDR_W(ADDR_W)) i_iplr_regs_asserts (.CLK(CLK), .NRST(NRST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ_IN(IRQ_IN), .IRQ_OUT(IRQ_OUT));
